// ### include/liucfg_pkg.sv
// Package for the control mode and pin configuration block
package liucfg_pkg;

    // ------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        LIUCFG_CTRL_HW = 2'b00,
        LIUCFG_CTRL_SERIAL = 2'b01,
        LIUCFG_CTRL_PAR_RW = 2'b10,
        LIUCFG_CTRL_PAR_STROBE = 2'b11
    } liucfg_ctrl_mode_t;

    typedef enum logic [1:0]
    {
        LIUCFG_FMT_SR_HDB3 = 2'b00,
        LIUCFG_FMT_SR_AMI = 2'b01,
        LIUCFG_FMT_DR_CDR = 2'b10,
        LIUCFG_FMT_SLICER = 2'b11
    } liucfg_format_t;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [1:0] LIUCFG_RST_MODE = 2'h0;
    localparam logic [1:0] LIUCFG_RST_FORMAT = 2'h0;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed
    {
        logic pulse_template_select;
        logic driver_high_z;
        logic rx_edge_select;
        logic [1:0] loopback_select;
        logic [1:0] pattern_select;
        logic [1:0] jitter_atten_select;
        logic monitor_gain_select;
        logic term_select;
        logic receiver_power_down;
        logic [1:0] line_format_select;
    } liucfg_hw_pins_t;

    typedef struct packed
    {
        logic single_rail;
        logic hdb3_enable;
        logic clock_data_recovery;
        logic rx_clk_falling;
        logic pulse_template_select;
        logic driver_high_z;
        logic [1:0] loopback_select;
        logic [1:0] pattern_select;
        logic [1:0] jitter_atten_select;
        logic monitor_gain_select;
        logic term_select;
        logic receiver_power_down;
    } liucfg_hw_cfg_t;

    typedef struct packed
    {
        logic strap_taken;
        liucfg_ctrl_mode_t mode;
        logic hw_mode;
        logic serial_en;
        logic par_rw_en;
        logic par_strobe_en;
        logic port_access;
        logic sout_on_fall;
        logic shift_prev;
        logic shift_rise;
        logic shift_fall;
        logic sout_launch;
        logic sin_sample;
        liucfg_format_t format;
        liucfg_hw_cfg_t hw_cfg;
    } liucfg_state_t;

endpackage

// ### design/liucfg_top.sv
// Control mode decode and hardware pin configuration of the line interface
`timescale 1ns/10ps
// Functional notes
// - Strap 00 hardware, 01 serial, 10 parallel bus with read/write select.
// - Strap 11 selects parallel bus with separate read and write strobes.
// - Serial mode uses shift edge select to pick the serial output shift edge.
// - Serial output on falling edge when select high, rising when low; input rising.
// - Hardware mode takes configuration from dedicated pins.
// - Hardware mode, receive edge select low: rising receive clock edge active.
// - Hardware mode, receive edge select high: falling receive clock edge active.
// - Microcontroller port responds only while active-low select is low.
// - Hardware mode format 00: single rail with HDB3.
// - Hardware mode format 01: single rail with AMI.
// - Hardware mode format 10: dual rail with clock data recovery.
// - Hardware mode format 11: slicer, dual rail without clock data recovery.
module liucfg_top
    import liucfg_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Straps and select
    input wire logic [1:0] ctrl_mode_strap,
    input wire logic chip_select_n,
    // Serial port timing
    input wire logic shift_clk,
    input wire logic shift_edge_select,
    // Hardware configuration pins
    input wire liucfg_hw_pins_t hw_pins,
    // Decoded control mode
    output liucfg_ctrl_mode_t ctrl_mode,
    output logic mode_valid,
    output logic hw_mode,
    output logic serial_en,
    output logic par_rw_en,
    output logic par_strobe_en,
    output logic port_access,
    // Serial strobes
    output logic serial_out_launch,
    output logic serial_in_sample,
    // Hardware configuration result
    output liucfg_hw_cfg_t hw_cfg
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    liucfg_state_t state;
    liucfg_state_t next_state;
    logic in_sw;

    always_comb
    begin
        next_state = state;
        in_sw = 1'b0;
        // The strap is caught once after reset release, never during reset
        if (!state.strap_taken)
        begin
            next_state.strap_taken = 1'b1;
            next_state.mode = liucfg_ctrl_mode_t'(ctrl_mode_strap);
        end
        next_state.hw_mode = state.strap_taken && (state.mode == LIUCFG_CTRL_HW);
        next_state.serial_en = state.strap_taken && (state.mode == LIUCFG_CTRL_SERIAL);
        next_state.par_rw_en = state.strap_taken && (state.mode == LIUCFG_CTRL_PAR_RW);
        next_state.par_strobe_en = state.strap_taken && (state.mode == LIUCFG_CTRL_PAR_STROBE);
        in_sw = state.strap_taken && (state.mode != LIUCFG_CTRL_HW);
        next_state.port_access = in_sw && !chip_select_n;

        // Shift clock edges are seen through the system clock
        next_state.shift_prev = shift_clk;
        next_state.shift_rise = shift_clk && !state.shift_prev;
        next_state.shift_fall = !shift_clk && state.shift_prev;
        next_state.sout_on_fall = shift_edge_select;
        next_state.sout_launch = state.serial_en && !chip_select_n
            && (state.sout_on_fall ? state.shift_fall : state.shift_rise);
        next_state.sin_sample = state.serial_en && !chip_select_n && state.shift_rise;

        // Hardware pins only take effect in hardware mode; else held at defaults
        if (state.hw_mode)
        begin
            next_state.format = liucfg_format_t'(hw_pins.line_format_select);
            next_state.hw_cfg.rx_clk_falling = hw_pins.rx_edge_select;
            next_state.hw_cfg.pulse_template_select = hw_pins.pulse_template_select;
            next_state.hw_cfg.driver_high_z = hw_pins.driver_high_z;
            next_state.hw_cfg.loopback_select = hw_pins.loopback_select;
            next_state.hw_cfg.pattern_select = hw_pins.pattern_select;
            next_state.hw_cfg.jitter_atten_select = hw_pins.jitter_atten_select;
            next_state.hw_cfg.monitor_gain_select = hw_pins.monitor_gain_select;
            next_state.hw_cfg.term_select = hw_pins.term_select;
            next_state.hw_cfg.receiver_power_down = hw_pins.receiver_power_down;
        end
        else
        begin
            // Receive edge pin is ignored in software mode
            next_state.format = liucfg_format_t'(LIUCFG_RST_FORMAT);
            next_state.hw_cfg = '0;
        end
        unique case (next_state.format)
            LIUCFG_FMT_SR_HDB3:
            begin
                next_state.hw_cfg.single_rail = 1'b1;
                next_state.hw_cfg.hdb3_enable = 1'b1;
                next_state.hw_cfg.clock_data_recovery = 1'b1;
            end
            LIUCFG_FMT_SR_AMI:
            begin
                next_state.hw_cfg.single_rail = 1'b1;
                next_state.hw_cfg.hdb3_enable = 1'b0;
                next_state.hw_cfg.clock_data_recovery = 1'b1;
            end
            LIUCFG_FMT_DR_CDR:
            begin
                next_state.hw_cfg.single_rail = 1'b0;
                next_state.hw_cfg.hdb3_enable = 1'b0;
                next_state.hw_cfg.clock_data_recovery = 1'b1;
            end
            LIUCFG_FMT_SLICER:
            begin
                next_state.hw_cfg.single_rail = 1'b0;
                next_state.hw_cfg.hdb3_enable = 1'b0;
                next_state.hw_cfg.clock_data_recovery = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state <= '0;
            state.mode <= liucfg_ctrl_mode_t'(LIUCFG_RST_MODE);
        end
        else
        begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign ctrl_mode = state.mode;
    assign mode_valid = state.strap_taken;
    assign hw_mode = state.hw_mode;
    assign serial_en = state.serial_en;
    assign par_rw_en = state.par_rw_en;
    assign par_strobe_en = state.par_strobe_en;
    assign port_access = state.port_access;
    assign serial_out_launch = state.sout_launch;
    assign serial_in_sample = state.sin_sample;
    assign hw_cfg = state.hw_cfg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    a_mode_held: assert property (mode_valid && $past(mode_valid) |-> $stable(ctrl_mode))
        else $error("control mode changed after strap");
    a_strap_taken: assert property ($fell(reset) |=> mode_valid && ctrl_mode == $past(ctrl_mode_strap))
        else $error("strap not caught after reset");
    a_hw_decode: assert property (mode_valid && ctrl_mode == LIUCFG_CTRL_HW |=> hw_mode && !serial_en)
        else $error("hardware mode not decoded");
    a_strobe_decode: assert property (mode_valid && ctrl_mode == LIUCFG_CTRL_PAR_STROBE |=> par_strobe_en)
        else $error("strobe bus mode not decoded");
    a_port_gate: assert property (port_access |-> !$past(chip_select_n) && !hw_mode)
        else $error("port access without select");
    a_sout_edge: assert property (serial_out_launch |-> $past(shift_edge_select, 3) ? !$past(shift_clk, 2)
        : $past(shift_clk, 2))
        else $error("serial output on wrong edge");
    a_sin_rise: assert property (serial_in_sample |-> $past(shift_clk, 2) && !$past(shift_clk, 3))
        else $error("serial input not on rising edge");
    a_rx_edge: assert property (hw_mode |=> hw_cfg.rx_clk_falling == $past(hw_pins.rx_edge_select))
        else $error("receive edge not following pin");
    a_slicer_fmt: assert property (hw_mode && hw_pins.line_format_select == 2'h3 |=>
        !hw_cfg.single_rail && !hw_cfg.clock_data_recovery)
        else $error("slicer mode wrong");
    a_hdb3_fmt: assert property (hw_mode && hw_pins.line_format_select == 2'h0 |=>
        hw_cfg.single_rail && hw_cfg.hdb3_enable)
        else $error("single rail HDB3 wrong");

    // ------------------------------------------------------------
    // Mode decode checks
    // ------------------------------------------------------------
    a_serial_decode: assert property (mode_valid && ctrl_mode == LIUCFG_CTRL_SERIAL |=>
        serial_en && !hw_mode && !par_rw_en && !par_strobe_en)
        else $error("serial mode not decoded");
    a_rw_decode: assert property (mode_valid && ctrl_mode == LIUCFG_CTRL_PAR_RW |=>
        par_rw_en && !hw_mode && !serial_en && !par_strobe_en)
        else $error("read write bus mode not decoded");
    a_mode_onehot: assert property (
        $onehot0({hw_mode, serial_en, par_rw_en, par_strobe_en}))
        else $error("more than one control mode active");
    a_decode_wait: assert property (!mode_valid |->
        !hw_mode && !serial_en && !par_rw_en && !par_strobe_en)
        else $error("mode decoded before strap taken");
    a_valid_held: assert property (mode_valid |=>
        mode_valid)
        else $error("strap lost while running");
    a_hw_match: assert property (hw_mode |->
        ctrl_mode == LIUCFG_CTRL_HW)
        else $error("hardware mode without matching strap");
    a_serial_match: assert property (serial_en |->
        ctrl_mode == LIUCFG_CTRL_SERIAL)
        else $error("serial mode without matching strap");
    a_rw_match: assert property (par_rw_en |->
        ctrl_mode == LIUCFG_CTRL_PAR_RW)
        else $error("read write bus mode without matching strap");
    a_strobe_match: assert property (par_strobe_en |->
        ctrl_mode == LIUCFG_CTRL_PAR_STROBE)
        else $error("strobe bus mode without matching strap");

    // ------------------------------------------------------------
    // Port gating checks
    // ------------------------------------------------------------
    a_port_hw_block: assert property (hw_mode |->
        !port_access)
        else $error("port open in hardware mode");
    a_port_deselect: assert property (chip_select_n |=>
        !port_access)
        else $error("port open while deselected");
    a_port_open: assert property ((serial_en || par_rw_en || par_strobe_en) && !chip_select_n |=>
        port_access)
        else $error("port closed while selected");
    a_launch_deselect: assert property (chip_select_n |=>
        !serial_out_launch && !serial_in_sample)
        else $error("serial strobe while deselected");

    // ------------------------------------------------------------
    // Serial strobe checks
    // ------------------------------------------------------------
    // Strobes trail the shift edge by two clocks: one to detect it, one to launch
    a_launch_mode: assert property (!serial_en |=>
        !serial_out_launch && !serial_in_sample)
        else $error("serial strobe outside serial mode");
    a_sin_follow: assert property ($rose(shift_clk) && serial_en
        ##1 !chip_select_n |=> serial_in_sample)
        else $error("rising shift edge not sampled");
    a_sout_rise_follow: assert property ($rose(shift_clk) && serial_en && !shift_edge_select
        ##1 !chip_select_n |=> serial_out_launch)
        else $error("rising shift edge not launched");
    a_sout_fall_follow: assert property ($fell(shift_clk) && serial_en && shift_edge_select
        ##1 !chip_select_n |=> serial_out_launch)
        else $error("falling shift edge not launched");
    a_sout_low_sel: assert property (serial_in_sample && !$past(shift_edge_select, 3) |->
        serial_out_launch)
        else $error("output not launched with input on rising edge");
    a_sout_high_sel: assert property (serial_out_launch && $past(shift_edge_select, 3) |->
        !serial_in_sample)
        else $error("output launched on rising edge with falling select");
    a_sin_single: assert property (serial_in_sample |=>
        !serial_in_sample)
        else $error("input sample longer than one cycle");

    // ------------------------------------------------------------
    // Pin configuration checks
    // ------------------------------------------------------------
    a_pin_pulse: assert property (hw_mode |=>
        hw_cfg.pulse_template_select == $past(hw_pins.pulse_template_select))
        else $error("pulse template not following pin");
    a_pin_high_z: assert property (hw_mode |=>
        hw_cfg.driver_high_z == $past(hw_pins.driver_high_z))
        else $error("driver high impedance not following pin");
    a_pin_loopback: assert property (hw_mode |=>
        hw_cfg.loopback_select == $past(hw_pins.loopback_select))
        else $error("loopback not following pins");
    a_pin_pattern: assert property (hw_mode |=>
        hw_cfg.pattern_select == $past(hw_pins.pattern_select))
        else $error("pattern not following pins");
    a_pin_jitter: assert property (hw_mode |=>
        hw_cfg.jitter_atten_select == $past(hw_pins.jitter_atten_select))
        else $error("jitter attenuator not following pins");
    a_pin_monitor: assert property (hw_mode |=>
        hw_cfg.monitor_gain_select == $past(hw_pins.monitor_gain_select))
        else $error("monitor gain not following pin");
    a_pin_term: assert property (hw_mode |=>
        hw_cfg.term_select == $past(hw_pins.term_select))
        else $error("termination not following pin");
    a_pin_power: assert property (hw_mode |=>
        hw_cfg.receiver_power_down == $past(hw_pins.receiver_power_down))
        else $error("receiver power down not following pin");
    a_ami_fmt: assert property (hw_mode && hw_pins.line_format_select == 2'h1 |=>
        hw_cfg.single_rail && !hw_cfg.hdb3_enable && hw_cfg.clock_data_recovery)
        else $error("single rail AMI wrong");
    a_dual_fmt: assert property (hw_mode && hw_pins.line_format_select == 2'h2 |=>
        !hw_cfg.single_rail && !hw_cfg.hdb3_enable && hw_cfg.clock_data_recovery)
        else $error("dual rail with recovery wrong");
    a_hdb3_recover: assert property (hw_mode && hw_pins.line_format_select == 2'h0 |=>
        hw_cfg.clock_data_recovery)
        else $error("single rail HDB3 without recovery");
    // Outside hardware mode the pins are ignored, so an untied pin cannot leak in
    a_sw_defaults: assert property (!hw_mode |=>
        !hw_cfg.rx_clk_falling && hw_cfg.single_rail && hw_cfg.hdb3_enable)
        else $error("pin configuration leaked outside hardware mode");

    // ------------------------------------------------------------
    // Cover points
    // ------------------------------------------------------------
    c_serial: cover property (serial_en && serial_out_launch);
    c_hw_dual: cover property (hw_mode ##1 hw_cfg.clock_data_recovery && !hw_cfg.single_rail);
    c_strobe_access: cover property (par_strobe_en && port_access);
    c_serial_fall: cover property (serial_en && serial_out_launch && !serial_in_sample);
    c_strap_ignored: cover property (mode_valid && ctrl_mode != ctrl_mode_strap);

endmodule

// ### test/liucfg_host_model.sv
// Host model that drives the serial shift clock and the device select
`timescale 1ns/10ps
module liucfg_host_model
(
    // Clock
    input wire logic clk,
    // Host side pins
    output logic shift_clk,
    output logic chip_select_n
);
    // ------------------------------------------------------------
    // Idle levels
    // ------------------------------------------------------------
    // Shift clock stands still low outside frames
    initial
    begin
        shift_clk = 1'h0;
        chip_select_n = 1'h1;
    end

    // ------------------------------------------------------------
    // Host actions
    // ------------------------------------------------------------
    task automatic select(input logic sel_n);
        chip_select_n = sel_n;
    endtask

    // Each phase lasts three clocks, so the device sees every shift edge
    task automatic frame(input int n);
        repeat (2) @(posedge clk);
        for (int i = 0; i < 2 * n; i++)
        begin
            #1;
            shift_clk = ~shift_clk;
            repeat (3) @(posedge clk);
        end
        #1;
    endtask
endmodule

// ### test/liucfg_top_bench.sv
// Self-checking bench for the control mode and pin configuration block
`timescale 1ns/10ps
module liucfg_top_bench;
    import liucfg_pkg::*;
    logic clk = 1'h0;
    logic reset = 1'h1;
    logic [1:0] ctrl_mode_strap = 2'h0;
    logic shift_edge_select = 1'h0;
    liucfg_hw_pins_t hw_pins = '0;
    logic chip_select_n, shift_clk, mode_valid, hw_mode, serial_en, par_rw_en, par_strobe_en, port_access;
    logic serial_out_launch, serial_in_sample;
    liucfg_ctrl_mode_t ctrl_mode;
    liucfg_hw_cfg_t hw_cfg;
    int n_mismatch = 0;
    int samples_checked = 0;
    logic [22:0] lq[$];
    logic [1:0] pq[$];
    event look;

    always #4 clk = ~clk;

    liucfg_top liucfg_top_inst (.clk(clk), .reset(reset), .ctrl_mode_strap(ctrl_mode_strap),
        .chip_select_n(chip_select_n), .shift_clk(shift_clk), .shift_edge_select(shift_edge_select),
        .hw_pins(hw_pins), .ctrl_mode(ctrl_mode), .mode_valid(mode_valid), .hw_mode(hw_mode),
        .serial_en(serial_en), .par_rw_en(par_rw_en), .par_strobe_en(par_strobe_en),
        .port_access(port_access), .serial_out_launch(serial_out_launch),
        .serial_in_sample(serial_in_sample), .hw_cfg(hw_cfg));
    liucfg_host_model liucfg_host_model_inst (.clk(clk), .shift_clk(shift_clk), .chip_select_n(chip_select_n));

    // ------------------------------------------------------------
    // Expectations and comparison
    // ------------------------------------------------------------
    function automatic liucfg_hw_cfg_t exp_cfg(input liucfg_hw_pins_t p, input logic hw);
        liucfg_hw_cfg_t c;
        c = '0;
        c.single_rail = hw ? ~p.line_format_select[1] : 1'h1;
        c.hdb3_enable = hw ? p.line_format_select == 2'h0 : 1'h1;
        c.clock_data_recovery = hw ? p.line_format_select != 2'h3 : 1'h1;
        if (hw)
        begin
            c.rx_clk_falling = p.rx_edge_select;
            c.pulse_template_select = p.pulse_template_select;
            c.driver_high_z = p.driver_high_z;
            c.loopback_select = p.loopback_select;
            c.pattern_select = p.pattern_select;
            c.jitter_atten_select = p.jitter_atten_select;
            c.monitor_gain_select = p.monitor_gain_select;
            c.term_select = p.term_select;
            c.receiver_power_down = p.receiver_power_down;
        end
        return c;
    endfunction

    task automatic compare_level(input logic [22:0] got, input logic [22:0] want);
        samples_checked++;
        if (got !== want)
        begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h want=%h", $time, got, want);
        end
    endtask

    task automatic compare_pulse(input logic [1:0] got, input logic [1:0] want);
        samples_checked++;
        if (got !== want)
        begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h want=%h", $time, got, want);
        end
    endtask

    task automatic note(input logic [1:0] m, input logic pa);
        lq.push_back({1'h1, m, m == 2'h0, m == 2'h1, m == 2'h2, m == 2'h3, pa, exp_cfg(hw_pins, m == 2'h0)});
        -> look;
    endtask

    always @(look)
    begin
        compare_level({mode_valid, ctrl_mode, hw_mode, serial_en, par_rw_en, par_strobe_en, port_access, hw_cfg},
            lq.pop_front());
    end

    // A pulse with no note waiting compares against zero and fails
    always @(posedge clk)
    begin
        #2;
        if (serial_out_launch === 1'h1 || serial_in_sample === 1'h1)
            compare_pulse({serial_out_launch, serial_in_sample}, pq.size() > 0 ? pq.pop_front() : 2'h0);
    end

    // ------------------------------------------------------------
    // Drivers
    // ------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic shift_frame(input logic ses, input logic expect_on);
        shift_edge_select = ses;
        for (int i = 0; i < 2; i++)
            if (expect_on)
            begin
                pq.push_back({~ses, 1'h1});
                if (ses)
                    pq.push_back(2'h2);
            end
        liucfg_host_model_inst.frame(2);
        tick(1);
    endtask

    task automatic end_of_test;
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial
    begin
        #400000;
        n_mismatch++;
        end_of_test();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        void'($urandom(2));
        for (int m = 0; m < 4; m++)
        begin
            reset = 1'h1;
            ctrl_mode_strap = m[1:0];
            liucfg_host_model_inst.select(1'h1);
            tick(3);
            reset = 1'h0;
            tick(1);
            ctrl_mode_strap = 2'($urandom);
            tick(3);
            note(m[1:0], 1'h0);
            for (int f = 0; f < 8; f++)
            begin
                hw_pins = 14'($urandom);
                hw_pins.line_format_select = f[1:0];
                if (m != 0)
                    hw_pins.rx_edge_select = 1'h0;
                tick(2);
                note(m[1:0], 1'h0);
            end
            liucfg_host_model_inst.select(1'h0);
            tick(2);
            note(m[1:0], m != 0);
            shift_frame(1'h0, m == 1);
            shift_frame(1'h1, m == 1);
            liucfg_host_model_inst.select(1'h1);
            tick(2);
            note(m[1:0], 1'h0);
            shift_frame(1'h1, 1'h0);
            $display("test mode %0d done", m);
        end
        tick(4);
        if (pq.size() != 0)
            n_mismatch++;
        end_of_test();
    end
endmodule
